// ### common/optcfg_pkg.sv
/*
 * Constants and carrier types for the option-byte loader and the
 * memory-size selection register.
 * Assumes a flash option area readable one byte per request, and a CPU
 * memory port that performs whole-byte reads and writes.
 */
package optcfg_pkg;

    // ==========================================================
    // Option-byte area
    // ==========================================================
    localparam logic [15:0] OPT_WDT_ADDR   = 16'h0080;  // Watchdog option byte
    localparam logic [15:0] OPT_RSV0_ADDR  = 16'h0081;  // Reserved byte
    localparam logic [15:0] OPT_RSV1_ADDR  = 16'h0083;  // Reserved byte
    localparam logic [15:0] OPT_DBG_ADDR   = 16'h0084;  // Debug control byte
    localparam logic [7:0]  OPT_RSV_VALUE  = 8'h00;     // Required reserved content
    localparam logic [7:0]  DBG_FIELD_MASK = 8'h03;     // Debug-enable field

    // Debug-enable field codes
    localparam logic [1:0] DBG_OFF        = 2'h0;
    localparam logic [1:0] DBG_PROHIBITED = 2'h1;
    localparam logic [1:0] DBG_KEEP       = 2'h2;
    localparam logic [1:0] DBG_ERASE      = 2'h3;

    // ==========================================================
    // Memory-size selection register
    // ==========================================================
    localparam logic [15:0] MSS_ADDR  = 16'hfff0;
    localparam logic [7:0]  MSS_RESET = 8'hcf;
    localparam int          RAM_MSB   = 7;
    localparam int          RAM_LSB   = 5;
    localparam int          ZERO_BIT  = 4;
    localparam int          ROM_MSB   = 3;
    localparam int          ROM_LSB   = 0;

    // Working-memory codes and sizes in bytes
    localparam logic [2:0]  RAM_CODE_768  = 3'h0;
    localparam logic [2:0]  RAM_CODE_512  = 3'h2;
    localparam logic [2:0]  RAM_CODE_1024 = 3'h6;
    localparam logic [10:0] RAM_BYTES_512  = 11'h0200;
    localparam logic [10:0] RAM_BYTES_768  = 11'h0300;
    localparam logic [10:0] RAM_BYTES_1024 = 11'h0400;

    // Program-store codes and sizes in KB
    localparam logic [3:0] ROM_CODE_4  = 4'h1;
    localparam logic [3:0] ROM_CODE_8  = 4'h2;
    localparam logic [3:0] ROM_CODE_16 = 4'h4;
    localparam logic [3:0] ROM_CODE_24 = 4'h6;
    localparam logic [3:0] ROM_CODE_32 = 4'h8;
    localparam logic [5:0] ROM_KB_4  = 6'h04;
    localparam logic [5:0] ROM_KB_8  = 6'h08;
    localparam logic [5:0] ROM_KB_16 = 6'h10;
    localparam logic [5:0] ROM_KB_24 = 6'h18;
    localparam logic [5:0] ROM_KB_32 = 6'h20;

    // Loader states
    typedef enum logic [2:0] {
        LD_WDT, LD_RSV0, LD_RSV1, LD_DBG, LD_DONE
    } load_state_t;

    // Applied option settings
    typedef struct packed {
        logic [7:0] wdt_option;       // Raw watchdog byte, passed on
        logic       debug_enable;     // On-chip debug allowed
        logic       erase_on_fail;    // Erase flash on failed ID check
        logic       debug_code_bad;   // Prohibited debug code seen
        logic       reserved_bad;     // Reserved byte not zero
    } option_cfg_t;

endpackage : optcfg_pkg

// ### logic/option_size_config.sv
/*
 * Reset-time option-byte loader and memory-size selection register.
 * Assumes the flash option area answers a read with data in the same cycle
 * as the request, and that the CPU port writes whole bytes only.
 */
// Notes on behaviour
// - Read option area automatically after reset release
// - Hold CPU in reset until options applied
// - Debug field bits 1:0; 00 off, 01 prohibited
// - Code 10: debug on, keep flash
// - Code 11: debug on, erase flash
// - Any reset loads size register with CF
// - Bits 7:5 select working memory size
// - Bits 3:0 select program store size
`timescale 1ns/1ps

module option_size_config
    import optcfg_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Flash option area
    output logic [15:0]      opt_addr,
    output logic             opt_rd,
    input  wire logic [7:0]  opt_data,
    // CPU memory port
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic [7:0]  cpu_wdata,
    output logic [7:0]       cpu_rdata,
    // Applied configuration
    output logic             cpu_run,
    output option_cfg_t      option_cfg,
    output logic [10:0]      workmem_bytes,
    output logic [5:0]       program_store_kb
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        load_state_t st;           // Loader progress
        logic        rd_pend;      // Read issued, data due this cycle
        logic [15:0] addr;         // Address presented to flash
        option_cfg_t cfg;          // Settings gathered so far
        logic        run;          // CPU released
        logic [7:0]  mss;          // Memory-size selection
        logic [7:0]  rdata;        // Read data to CPU
        logic [10:0] ram_bytes;    // Decoded working memory size
        logic [5:0]  rom_kb;       // Decoded program store size
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Working memory decode; prohibited codes fall back to the smallest
    // size so a bad write can never expose more than exists.
    function automatic logic [10:0] ram_size(input logic [2:0] code);
        case (code)
            RAM_CODE_768:  ram_size = RAM_BYTES_768;
            RAM_CODE_512:  ram_size = RAM_BYTES_512;
            RAM_CODE_1024: ram_size = RAM_BYTES_1024;
            default:       ram_size = RAM_BYTES_512;
        endcase
    endfunction : ram_size

    // Program store decode with the same safe fallback
    function automatic logic [5:0] rom_size(input logic [3:0] code);
        case (code)
            ROM_CODE_4:  rom_size = ROM_KB_4;
            ROM_CODE_8:  rom_size = ROM_KB_8;
            ROM_CODE_16: rom_size = ROM_KB_16;
            ROM_CODE_24: rom_size = ROM_KB_24;
            ROM_CODE_32: rom_size = ROM_KB_32;
            default:     rom_size = ROM_KB_4;
        endcase
    endfunction : rom_size

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        state_next = state_reg;
        state_next.rd_pend = 1'b0;
        // Loader walks the option bytes, one read and one capture each
        case (state_reg.st)
            LD_WDT, LD_RSV0, LD_RSV1, LD_DBG:
            begin
                if (!state_reg.rd_pend)
                begin
                    // Issue read for the current byte
                    state_next.rd_pend = 1'b1;
                end
                else
                begin
                    // Capture the returned byte
                    case (state_reg.st)
                        LD_WDT:
                        begin
                            state_next.cfg.wdt_option = opt_data;
                            state_next.st   = LD_RSV0;
                            state_next.addr = OPT_RSV0_ADDR;
                        end
                        LD_RSV0:
                        begin
                            if (opt_data != OPT_RSV_VALUE)
                                state_next.cfg.reserved_bad = 1'b1;
                            state_next.st   = LD_RSV1;
                            state_next.addr = OPT_RSV1_ADDR;
                        end
                        LD_RSV1:
                        begin
                            if (opt_data != OPT_RSV_VALUE)
                                state_next.cfg.reserved_bad = 1'b1;
                            state_next.st   = LD_DBG;
                            state_next.addr = OPT_DBG_ADDR;
                        end
                        default:
                        begin
                            // Upper bits ignored; only the field counts
                            case (opt_data[1:0] & DBG_FIELD_MASK[1:0])
                                DBG_KEEP:
                                    state_next.cfg.debug_enable = 1'b1;
                                DBG_ERASE:
                                begin
                                    state_next.cfg.debug_enable  = 1'b1;
                                    state_next.cfg.erase_on_fail = 1'b1;
                                end
                                DBG_PROHIBITED:
                                    state_next.cfg.debug_code_bad = 1'b1;
                                default:
                                    state_next.cfg.debug_enable = 1'b0;
                            endcase
                            state_next.st  = LD_DONE;
                            state_next.run = 1'b1;
                        end
                    endcase
                end
            end
            default:
            begin
                // Normal operation: options frozen until next reset
                state_next.run = 1'b1;
            end
        endcase

        // Whole-byte register write; bit 4 forced to zero
        if (cpu_wr && cpu_addr == MSS_ADDR)
        begin
            state_next.mss = cpu_wdata;
            state_next.mss[ZERO_BIT] = 1'b0;
        end
        // Read data, unmapped addresses return zero
        state_next.rdata = (cpu_addr == MSS_ADDR) ? state_reg.mss : 8'h00;
        // Decoded sizes follow the register one cycle later
        state_next.ram_bytes = ram_size(state_reg.mss[RAM_MSB:RAM_LSB]);
        state_next.rom_kb    = rom_size(state_reg.mss[ROM_MSB:ROM_LSB]);

        if (reset)
        begin
            state_next           = '0;
            state_next.st        = LD_WDT;
            state_next.addr      = OPT_WDT_ADDR;
            state_next.mss       = MSS_RESET;
            state_next.ram_bytes = ram_size(MSS_RESET[RAM_MSB:RAM_LSB]);
            state_next.rom_kb    = rom_size(MSS_RESET[ROM_MSB:ROM_LSB]);
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        state_reg <= state_next;
    end

    // Outputs straight from the state flops
    assign opt_addr         = state_reg.addr;
    assign opt_rd           = state_reg.rd_pend;
    assign cpu_rdata        = state_reg.rdata;
    assign cpu_run          = state_reg.run;
    assign option_cfg       = state_reg.cfg;
    assign workmem_bytes    = state_reg.ram_bytes;
    assign program_store_kb = state_reg.rom_kb;

    // ==========================================================
    // Assertions
    // ==========================================================
    reset_value_a: assert property (@(posedge sys_clk)
        $past(reset) && !reset |-> state_reg.mss == MSS_RESET && !cpu_run)
        else $error("Size register not CF after reset");

    cpu_held_a: assert property (@(posedge sys_clk) disable iff (reset)
        cpu_run |-> state_reg.st == LD_DONE)
        else $error("CPU released before options applied");

    load_time_a: assert property (@(posedge sys_clk)
        $fell(reset) |-> ##8 cpu_run)
        else $error("Option load did not finish in 8 cycles");

    debug_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg.st == LD_DBG && opt_rd && opt_data[1:0] == DBG_KEEP
        |=> option_cfg.debug_enable && !option_cfg.erase_on_fail)
        else $error("Debug keep code misapplied");

    debug_erase_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg.st == LD_DBG && opt_rd && opt_data[1:0] == DBG_ERASE
        |=> option_cfg.debug_enable && option_cfg.erase_on_fail)
        else $error("Debug erase code misapplied");

    debug_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        option_cfg.debug_code_bad |-> !option_cfg.debug_enable)
        else $error("Prohibited debug code enabled debug");

    zero_bit_a: assert property (@(posedge sys_clk) disable iff (reset)
        cpu_wr && cpu_addr == MSS_ADDR |=> ##1 cpu_rdata[ZERO_BIT] == 1'b0)
        else $error("Bit 4 read back nonzero");

    write_back_a: assert property (@(posedge sys_clk) disable iff (reset)
        cpu_wr && cpu_addr == MSS_ADDR ##1 cpu_addr == MSS_ADDR && !cpu_wr
        |=> cpu_rdata[RAM_MSB:RAM_LSB] == $past(cpu_wdata[RAM_MSB:RAM_LSB], 2))
        else $error("Size register write lost");

    size_cap_a: assert property (@(posedge sys_clk) disable iff (reset)
        workmem_bytes <= RAM_BYTES_1024 && program_store_kb <= ROM_KB_32)
        else $error("Decoded size beyond largest defined");

    ram_decode_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg.mss[RAM_MSB:RAM_LSB] == RAM_CODE_1024
        |=> workmem_bytes == RAM_BYTES_1024)
        else $error("Working memory decode wrong");

    rom_decode_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg.mss[ROM_MSB:ROM_LSB] == ROM_CODE_24 |=> program_store_kb == ROM_KB_24)
        else $error("Program store decode wrong");

endmodule : option_size_config

// ### tb/option_flash_model.sv
/*
 * Model of the flash option area that the loader reads after reset.
 * Assumes the loader wants each byte during the cycle its read strobe is high.
 */
`timescale 1ns/1ps
module option_flash_model
    import optcfg_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Loader side
    input  wire logic [15:0] opt_addr,
    input  wire logic        opt_rd,
    output logic [7:0]       opt_data,
    // Image contents set by the bench
    input  wire logic [7:0]  img_wdt,
    input  wire logic [7:0]  img_rsv0,
    input  wire logic [7:0]  img_rsv1,
    input  wire logic [7:0]  img_dbg
);
    // ==========================================================
    // Byte select
    // ==========================================================
    logic [7:0] cur_byte;           // Byte at the requested address
    logic [7:0] last_reg = 8'h00;   // Last byte handed out

    // Decode the option address into the image byte
    always_comb
    begin
        case (opt_addr)
            OPT_WDT_ADDR:  cur_byte = img_wdt;
            OPT_RSV0_ADDR: cur_byte = img_rsv0;
            OPT_RSV1_ADDR: cur_byte = img_rsv1;
            OPT_DBG_ADDR:  cur_byte = img_dbg;
            default:       cur_byte = 8'h5a;     // Unread bytes hold junk
        endcase
    end

    // Remember the last byte so the idle bus can show its inverse
    always_ff @(posedge sys_clk)
    begin
        if (opt_rd)
            last_reg <= cur_byte;
    end

    // Outside a read the data is stale, so a late capture sees wrong bits
    assign opt_data = opt_rd ? cur_byte : ~last_reg;
endmodule : option_flash_model

// ### tb/option_size_config_tb.sv
/*
 * Self-checking bench for the option loader and memory-size register.
 * Assumes the flash model above and a 40 MHz clock driven from here.
 */
`timescale 1ns/1ps
module option_size_config_tb;
    import optcfg_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic        sys_clk = 1'b0;      // System clock
    logic        reset = 1'b1;        // Synchronous reset
    logic [15:0] opt_addr;            // Loader address
    logic        opt_rd;              // Loader strobe
    logic [7:0]  opt_data;            // Flash answer
    logic [15:0] cpu_addr = 16'h0000; // CPU address
    logic        cpu_wr = 1'b0;       // CPU write strobe
    logic [7:0]  cpu_wdata = 8'h00;   // CPU write data
    logic [7:0]  cpu_rdata;           // CPU read data
    logic        cpu_run;             // Options applied
    option_cfg_t cfg;                 // Applied options
    logic [10:0] workmem_bytes;       // Decoded RAM size
    logic [5:0]  program_store_kb;    // Decoded ROM size
    logic [7:0]  img [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // Flash image
    int          n_mismatch = 0;      // Mismatches seen
    int          cmp_count = 0;       // Comparisons made
    // Writes with bit 4 set; expected readback, RAM bytes, ROM KB
    logic [7:0]  wv [7] = '{8'h11, 8'h52, 8'hd4, 8'h16, 8'hd8, 8'hff, 8'h39};
    logic [7:0]  rv [7] = '{8'h01, 8'h42, 8'hc4, 8'h06, 8'hc8, 8'hef, 8'h29};
    logic [10:0] ram [7] = '{11'h300, 11'h200, 11'h400, 11'h300, 11'h400, 11'h200, 11'h200};
    logic [5:0]  rom [7] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h20, 6'h04, 6'h04};
    logic [15:0] ord [4] = '{16'h0080, 16'h0081, 16'h0083, 16'h0084};

    always #12.5 sys_clk = ~sys_clk;

    option_size_config option_size_config_i (.sys_clk(sys_clk), .reset(reset),
        .opt_addr(opt_addr), .opt_rd(opt_rd), .opt_data(opt_data), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_run(cpu_run),
        .option_cfg(cfg), .workmem_bytes(workmem_bytes), .program_store_kb(program_store_kb));
    option_flash_model option_flash_model_i (.sys_clk(sys_clk), .opt_addr(opt_addr),
        .opt_rd(opt_rd), .opt_data(opt_data), .img_wdt(img[0]), .img_rsv0(img[1]),
        .img_rsv1(img[2]), .img_dbg(img[3]));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Reset with a given image, record loader reads until the CPU may run
    task automatic boot(input logic [7:0] w, input logic [7:0] r1, input logic [7:0] d);
        logic [15:0] seen [$];
        img = '{w, 8'h00, r1, d};
        reset = 1'b1;
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        chk("run_early", 16'h0000, 16'(cpu_run));
        for (int i = 0; i < 30 && cpu_run !== 1'b1; i++)
        begin
            if (opt_rd === 1'b1)
                seen.push_back(opt_addr);
            @(negedge sys_clk);
        end
        chk("run", 16'h0001, 16'(cpu_run));
        chk("reads", 16'h0004, 16'(seen.size()));
        foreach (seen[k]) chk("addr", ord[k], seen[k]);
        chk("wdt", 16'(w), 16'(cfg.wdt_option));
    endtask : boot

    // Whole-byte write, address then parked on the size register
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge sys_clk);
        cpu_wr = 1'b0;
        cpu_addr = MSS_ADDR;
        repeat (2) @(negedge sys_clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        cpu_addr = a;
        repeat (2) @(negedge sys_clk);
        chk("rdata", 16'(exp), 16'(cpu_rdata));
    endtask : rd_reg

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        boot(8'h30, 8'h00, 8'h00);
        rd_reg(MSS_ADDR, 8'hcf);
        chk("ram", 16'h0400, 16'(workmem_bytes));
        chk("rom", 16'h0004, 16'(program_store_kb));
        $display("Test reset_defaults finished");
        for (int c = 0; c < 4; c++)
        begin
            boot(8'h30, 8'h00, 8'(c));
            chk("dbg_on", 16'(c >= 2), 16'(cfg.debug_enable));
            chk("erase", 16'(c == 3), 16'(cfg.erase_on_fail));
            chk("dbg_bad", 16'(c == 1), 16'(cfg.debug_code_bad));
            chk("rsv_bad", 16'h0000, 16'(cfg.reserved_bad));
        end
        $display("Test debug_codes finished");
        boot(8'h7e, 8'h01, 8'h02);
        chk("rsv_bad", 16'h0001, 16'(cfg.reserved_bad));
        $display("Test reserved_flag finished");
        for (int k = 0; k < 7; k++)
        begin
            wr_reg(MSS_ADDR, wv[k]);
            chk("mss", 16'(rv[k]), 16'(cpu_rdata));
            chk("ram", 16'(ram[k]), 16'(workmem_bytes));
            chk("rom", 16'(rom[k]), 16'(program_store_kb));
        end
        $display("Test size_codes finished");
        wr_reg(16'hfff1, 8'hc8);
        chk("mss_kept", 16'h0029, 16'(cpu_rdata));
        rd_reg(16'hfff1, 8'h00);
        $display("Test other_address finished");
        // Mid-run reset must bring back the default sizes
        boot(8'h30, 8'h00, 8'h00);
        rd_reg(MSS_ADDR, 8'hcf);
        chk("ram", 16'h0400, 16'(workmem_bytes));
        chk("rom", 16'h0004, 16'(program_store_kb));
        // Software then programs the real capacity of the part
        wr_reg(MSS_ADDR, 8'hc8);
        chk("mss", 16'h00c8, 16'(cpu_rdata));
        chk("ram", 16'h0400, 16'(workmem_bytes));
        chk("rom", 16'h0020, 16'(program_store_kb));
        $display("Test second_reset finished");
        stop_test();
    end

    // Watchdog: the whole run needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        $display("ERROR watchdog expected end seen hang");
        stop_test();
    end
endmodule : option_size_config_tb
